/* rtl/sbt_decode.sv */
`timescale 1ns/1ps
// =====================================================================
// Timeout code to interval in seconds
module sbt_decode (
  input  wire logic [7:0]  code,
  output logic      [15:0] secs,
  output logic             enable,
  output logic             abort
);

  logic [15:0] code_w;

  always_comb begin
    code_w = {8'h00, code};
    secs   = 16'h0000;
    enable = 1'b1;
    abort  = 1'b0;
    if (code == sbt_pkg::CODE_OFF) begin
      enable = 1'b0;
    end else if (code <= sbt_pkg::CODE_LIN_MAX) begin
      secs = 16'(code_w * sbt_pkg::STEP_5S_SEC);
    end else if (code <= sbt_pkg::CODE_HALF_MAX) begin
      secs = 16'((code_w - {8'h00, sbt_pkg::CODE_LIN_MAX}) * sbt_pkg::STEP_30M_SEC);
    end else begin
      case (code)
        sbt_pkg::CODE_21M:   secs = sbt_pkg::T_21M_SEC;
        sbt_pkg::CODE_8H:    secs = sbt_pkg::T_8H_SEC;
        sbt_pkg::CODE_21M15: secs = sbt_pkg::T_21M15_SEC;
        default: begin
          enable = 1'b0;
          abort  = 1'b1;
        end
      endcase
    end
  end

endmodule

/* rtl/sbt_pkg.sv */
// =====================================================================
// Standby timer package
package sbt_pkg;

  // =====================================================================
  // Clock and time base
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned SEC_S       = 1;
  localparam int unsigned SEC_CYCLES  = CLK_HZ * SEC_S;

  // =====================================================================
  // Register map (byte addresses)
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_CTRL     = 8'h08;
  localparam logic [7:0] OFF_INT_STAT = 8'h0C;
  localparam logic [7:0] OFF_INT_MASK = 8'h10;
  localparam logic [7:0] OFF_TIMER    = 8'h14;

  // Command word fields
  localparam int unsigned CMD_OP_LSB   = 0;
  localparam int unsigned CMD_CODE_LSB = 8;

  // Status word fields
  localparam int unsigned ST_ERRF_LSB  = 0;
  localparam int unsigned ST_STATF_LSB = 8;
  localparam int unsigned ST_PWR_LSB   = 16;
  localparam int unsigned ST_SPIN_BIT  = 18;
  localparam int unsigned ST_ARM_BIT   = 19;

  // Control fields
  localparam int unsigned CTRL_EPC_BIT = 0;

  // =====================================================================
  // Command codes and flag bits
  localparam logic [7:0] OP_STANDBY     = 8'hE2;
  localparam logic [7:0] OP_STANDBY_ALT = 8'h96;
  localparam int unsigned ERR_ABT_BIT   = 2;
  localparam int unsigned STS_BSY_BIT   = 7;
  localparam int unsigned STS_RDY_BIT   = 6;
  localparam int unsigned STS_DSC_BIT   = 4;
  localparam int unsigned STS_ERR_BIT   = 0;

  // =====================================================================
  // Timeout code decode, in seconds
  localparam logic [7:0]  CODE_OFF       = 8'h00;
  localparam logic [7:0]  CODE_LIN_MAX   = 8'hF0;
  localparam logic [7:0]  CODE_HALF_MAX  = 8'hFB;
  localparam logic [7:0]  CODE_21M       = 8'hFC;
  localparam logic [7:0]  CODE_8H        = 8'hFD;
  localparam logic [7:0]  CODE_ABORT     = 8'hFE;
  localparam logic [7:0]  CODE_21M15    = 8'hFF;
  localparam logic [15:0] STEP_5S_SEC    = 16'h0005;
  localparam logic [15:0] STEP_30M_SEC   = 16'h0708;
  localparam logic [15:0] T_21M_SEC      = 16'h04EC;
  localparam logic [15:0] T_8H_SEC       = 16'h7080;
  localparam logic [15:0] T_21M15_SEC    = 16'h04FB;

  // =====================================================================
  // Interrupt events
  localparam int unsigned INT_W        = 4;
  localparam int unsigned EV_CMD_DONE  = 0;
  localparam int unsigned EV_ABORT     = 1;
  localparam int unsigned EV_AUTO_SB   = 2;
  localparam int unsigned EV_SPUN_UP   = 3;

  // Reset values
  localparam logic [15:0] RST_INTERVAL = 16'h0000;

  typedef enum logic [1:0] {
    SBT_IDLE,
    SBT_STANDBY,
    SBT_SPINUP
  } sbt_state_t;

endpackage

/* rtl/sbt_top.sv */
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// How it works
// - E2h and 96h both mean standby
// - Command enters standby, loads timeout
// - Standby stops spindle, interface stays live
// - Already stopped: no spin-down, stay stopped
// - Host access in standby spins up, busy until at speed
// - Countdown runs only back in idle
// - EPC enabled: standby command sets standby_z; expiry does not
// - Code 0 off, linear 5s/30min steps
// - Codes 252,253,255 fixed; 254 aborts
// - Expiry without access enters standby
// - Host access reloads full interval
module sbt_top #(
  parameter int unsigned TICK_CYCLES = sbt_pkg::SEC_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        host_access,
  input  wire logic        spindle_at_speed,
  output logic             spindle_run,
  output logic             standby,
  output logic             standby_z,
  output logic             cmd_busy,
  output logic             irq
);

  // =====================================================================
  // Input synchronisers
  logic host_m_reg, host_s_reg, speed_m_reg, speed_s_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_m_reg  <= 1'b0;
      host_s_reg  <= 1'b0;
      speed_m_reg <= 1'b0;
      speed_s_reg <= 1'b0;
    end else begin
      host_m_reg  <= host_access;
      host_s_reg  <= host_m_reg;
      speed_m_reg <= spindle_at_speed;
      speed_s_reg <= speed_m_reg;
    end
  end

  // =====================================================================
  // APB slave: one wait state, answer registered
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        apb_wr, addr_ok;
  logic [31:0] rdata;

  logic        epc_reg, epc_next;
  logic [sbt_pkg::INT_W-1:0] ist_reg, ist_next, imask_reg, imask_next;
  logic [7:0]  errf_reg, errf_next;
  logic [7:0]  statf;

  sbt_pkg::sbt_state_t state_reg, state_next;
  logic [15:0] interval_reg, interval_next;
  logic [15:0] remain_reg, remain_next;
  logic [31:0] pre_reg, pre_next;
  logic        armed_reg, armed_next;
  logic        spin_reg, spin_next;
  logic        sbz_reg, sbz_next;
  logic        irq_reg, irq_next;
  logic        standby_reg, busy_reg;

  always_comb begin
    addr_ok = (paddr == sbt_pkg::OFF_CMD) || (paddr == sbt_pkg::OFF_STATUS) ||
              (paddr == sbt_pkg::OFF_CTRL) || (paddr == sbt_pkg::OFF_INT_STAT) ||
              (paddr == sbt_pkg::OFF_INT_MASK) || (paddr == sbt_pkg::OFF_TIMER);
    apb_wr  = psel && penable && pready_reg && pwrite && addr_ok;
  end

  // Status flags built from live state
  always_comb begin
    statf = 8'h00;
    statf[sbt_pkg::STS_BSY_BIT] = (state_reg == sbt_pkg::SBT_SPINUP);
    statf[sbt_pkg::STS_RDY_BIT] = 1'b1;
    statf[sbt_pkg::STS_DSC_BIT] = 1'b1;
    statf[sbt_pkg::STS_ERR_BIT] = errf_reg[sbt_pkg::ERR_ABT_BIT];
  end

  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      sbt_pkg::OFF_STATUS: begin
        rdata[sbt_pkg::ST_ERRF_LSB +: 8]  = errf_reg;
        rdata[sbt_pkg::ST_STATF_LSB +: 8] = statf;
        rdata[sbt_pkg::ST_PWR_LSB +: 2]   = state_reg;
        rdata[sbt_pkg::ST_SPIN_BIT]       = spin_reg;
        rdata[sbt_pkg::ST_ARM_BIT]        = armed_reg;
      end
      sbt_pkg::OFF_CTRL:     rdata[sbt_pkg::CTRL_EPC_BIT] = epc_reg;
      sbt_pkg::OFF_INT_STAT: rdata[sbt_pkg::INT_W-1:0] = ist_reg;
      sbt_pkg::OFF_INT_MASK: rdata[sbt_pkg::INT_W-1:0] = imask_reg;
      sbt_pkg::OFF_TIMER:    rdata = {interval_reg, remain_reg};
      default:               rdata = 32'h0000_0000;
    endcase
  end

  always_comb begin
    pready_next  = psel && penable && !pready_reg;
    pslverr_next = pready_next && !addr_ok;
    prdata_next  = pready_next ? rdata : prdata_reg;
  end

  // =====================================================================
  // Command decode
  logic [7:0]  opcode, tcode;
  logic [15:0] dec_secs;
  logic        dec_en, dec_abort;
  logic        cmd_fire, cmd_ok, cmd_bad;

  sbt_decode u_decode (
    .code   (tcode),
    .secs   (dec_secs),
    .enable (dec_en),
    .abort  (dec_abort)
  );

  always_comb begin
    opcode   = pwdata[sbt_pkg::CMD_OP_LSB +: 8];
    tcode    = pwdata[sbt_pkg::CMD_CODE_LSB +: 8];
    cmd_fire = apb_wr && (paddr == sbt_pkg::OFF_CMD);
    cmd_ok   = cmd_fire && !dec_abort &&
               ((opcode == sbt_pkg::OP_STANDBY) || (opcode == sbt_pkg::OP_STANDBY_ALT));
    cmd_bad  = cmd_fire && !cmd_ok;
  end

  // =====================================================================
  // Power state and timer
  logic tick, expire;

  always_comb begin
    tick   = (pre_reg == 32'(TICK_CYCLES - 1));
    expire = tick && armed_reg && (remain_reg <= 16'h0001);
  end

  always_comb begin
    state_next    = state_reg;
    interval_next = interval_reg;
    remain_next   = remain_reg;
    pre_next      = pre_reg;
    armed_next    = armed_reg;
    spin_next     = spin_reg;
    sbz_next      = sbz_reg;
    errf_next     = errf_reg;
    if (cmd_ok) begin
      state_next    = sbt_pkg::SBT_STANDBY;
      interval_next = dec_secs;
      remain_next   = dec_secs;
      armed_next    = dec_en;
      pre_next      = 32'h0000_0000;
      errf_next     = 8'h00;
      // Spindle off; no-op if already stopped
      spin_next     = 1'b0;
      sbz_next      = epc_reg;
    end else begin
      if (cmd_bad) begin
        errf_next = 8'h00;
        errf_next[sbt_pkg::ERR_ABT_BIT] = 1'b1;
      end
      case (state_reg)
        sbt_pkg::SBT_STANDBY: begin
          if (host_s_reg) begin
            state_next = sbt_pkg::SBT_SPINUP;
            spin_next  = 1'b1;
          end
        end
        sbt_pkg::SBT_SPINUP: begin
          if (speed_s_reg) begin
            state_next  = sbt_pkg::SBT_IDLE;
            sbz_next    = 1'b0;
            remain_next = interval_reg;
            pre_next    = 32'h0000_0000;
          end
        end
        sbt_pkg::SBT_IDLE: begin
          if (host_s_reg) begin
            remain_next = interval_reg;
            pre_next    = 32'h0000_0000;
          end else if (expire) begin
            state_next = sbt_pkg::SBT_STANDBY;
            spin_next  = 1'b0;
            pre_next   = 32'h0000_0000;
          end else begin
            pre_next = tick ? 32'h0000_0000 : pre_reg + 32'h0000_0001;
            if (tick && armed_reg) begin
              remain_next = remain_reg - 16'h0001;
            end
          end
        end
        default: state_next = sbt_pkg::SBT_IDLE;
      endcase
    end
  end

  // =====================================================================
  // Control and interrupts
  logic [sbt_pkg::INT_W-1:0] ev;

  always_comb begin
    ev = '0;
    ev[sbt_pkg::EV_CMD_DONE] = cmd_ok;
    ev[sbt_pkg::EV_ABORT]    = cmd_bad;
    ev[sbt_pkg::EV_AUTO_SB]  = (state_reg == sbt_pkg::SBT_IDLE) &&
                               (state_next == sbt_pkg::SBT_STANDBY);
    ev[sbt_pkg::EV_SPUN_UP]  = (state_reg == sbt_pkg::SBT_SPINUP) &&
                               (state_next == sbt_pkg::SBT_IDLE);
    epc_next   = epc_reg;
    imask_next = imask_reg;
    ist_next   = ist_reg;
    if (apb_wr && paddr == sbt_pkg::OFF_CTRL) begin
      epc_next = pwdata[sbt_pkg::CTRL_EPC_BIT];
    end
    if (apb_wr && paddr == sbt_pkg::OFF_INT_MASK) begin
      imask_next = pwdata[sbt_pkg::INT_W-1:0];
    end
    if (apb_wr && paddr == sbt_pkg::OFF_INT_STAT) begin
      ist_next = ist_reg & ~pwdata[sbt_pkg::INT_W-1:0];
    end
    // Set beats a clear in the same cycle
    ist_next = ist_next | ev;
    irq_next = |(ist_next & imask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      prdata_reg   <= 32'h0000_0000;
      state_reg    <= sbt_pkg::SBT_IDLE;
      interval_reg <= sbt_pkg::RST_INTERVAL;
      remain_reg   <= sbt_pkg::RST_INTERVAL;
      pre_reg      <= 32'h0000_0000;
      armed_reg    <= 1'b0;
      spin_reg     <= 1'b1;
      sbz_reg      <= 1'b0;
      errf_reg     <= 8'h00;
      epc_reg      <= 1'b0;
      imask_reg    <= '0;
      ist_reg      <= '0;
      irq_reg      <= 1'b0;
      standby_reg  <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
      prdata_reg   <= prdata_next;
      state_reg    <= state_next;
      interval_reg <= interval_next;
      remain_reg   <= remain_next;
      pre_reg      <= pre_next;
      armed_reg    <= armed_next;
      spin_reg     <= spin_next;
      sbz_reg      <= sbz_next;
      errf_reg     <= errf_next;
      epc_reg      <= epc_next;
      imask_reg    <= imask_next;
      ist_reg      <= ist_next;
      irq_reg      <= irq_next;
      standby_reg  <= (state_next == sbt_pkg::SBT_STANDBY);
      busy_reg     <= (state_next == sbt_pkg::SBT_SPINUP);
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign spindle_run = spin_reg;
  assign standby     = standby_reg;
  assign standby_z   = sbz_reg;
  assign cmd_busy    = busy_reg;
  assign irq         = irq_reg;

  // =====================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_alias;
    cmd_fire && opcode == sbt_pkg::OP_STANDBY_ALT && !dec_abort |=> standby && !spindle_run;
  endproperty
  a_alias: assert property (p_alias) else $error("alternate opcode not standby");

  property p_enter;
    cmd_ok |=> standby && remain_reg == $past(dec_secs) && ist_reg[sbt_pkg::EV_CMD_DONE];
  endproperty
  a_enter: assert property (p_enter) else $error("standby not entered or not loaded");

  property p_stopped;
    standby |-> !spindle_run;
  endproperty
  a_stopped: assert property (p_stopped) else $error("spindle runs in standby");

  property p_stay_stopped;
    standby && cmd_ok |=> !spindle_run && standby;
  endproperty
  a_stay_stopped: assert property (p_stay_stopped) else $error("spindle moved");

  property p_busy;
    state_reg == sbt_pkg::SBT_STANDBY && host_s_reg && !cmd_fire |=> cmd_busy && spindle_run;
  endproperty
  a_busy: assert property (p_busy) else $error("access in standby not held busy");

  property p_no_count;
    state_reg == sbt_pkg::SBT_STANDBY && !host_s_reg && !cmd_fire |=> $stable(remain_reg);
  endproperty
  a_no_count: assert property (p_no_count) else $error("timer counted in standby");

  property p_epc;
    cmd_ok && epc_reg |=> standby_z;
  endproperty
  a_epc: assert property (p_epc) else $error("standby_z not set");

  property p_decode;
    (tcode == 8'h00 |-> !dec_en) and (tcode == 8'hF1 |-> dec_secs == 16'h0708) and
    (tcode == 8'h01 |-> dec_secs == 16'h0005);
  endproperty
  a_decode: assert property (p_decode) else $error("timeout decode wrong");

  property p_special;
    (tcode == 8'hFD |-> dec_secs == 16'h7080) and (tcode == 8'hFE |-> dec_abort) and
    (tcode == 8'hFF |-> dec_secs == 16'h04FB);
  endproperty
  a_special: assert property (p_special) else $error("special code wrong");

  property p_expire;
    state_reg == sbt_pkg::SBT_IDLE && expire && !host_s_reg && !cmd_fire |=>
      standby ##0 !spindle_run;
  endproperty
  a_expire: assert property (p_expire) else $error("no auto standby on expiry");

  property p_reload;
    state_reg == sbt_pkg::SBT_IDLE && host_s_reg && !cmd_fire |=> remain_reg == interval_reg;
  endproperty
  a_reload: assert property (p_reload) else $error("access did not reload");

  property p_abort;
    cmd_bad |=> errf_reg[sbt_pkg::ERR_ABT_BIT] && statf[sbt_pkg::STS_ERR_BIT] &&
      !$changed(state_reg);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not flagged");

  c_cmd:    cover property (cmd_ok);
  c_auto:   cover property (ev[sbt_pkg::EV_AUTO_SB]);
  c_spinup: cover property (ev[sbt_pkg::EV_SPUN_UP]);
  c_abort:  cover property (cmd_bad ##1 irq);

endmodule

/* verif/sbt_spindle_model.sv */
`timescale 1ns/1ps
// =====================================================================
// Spindle motor stand-in, prompt or slow to reach speed
module sbt_spindle_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  input  wire logic spindle_run,
  output logic      spindle_at_speed
);
  int unsigned ramp;

  // Speed lost at once when off, regained after a ramp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp             <= 0;
      spindle_at_speed <= 1'b1;
    end else if (!spindle_run) begin
      ramp             <= 0;
      spindle_at_speed <= 1'b0;
    end else begin
      ramp             <= ramp + 1;
      spindle_at_speed <= (ramp >= (slow ? 40 : 3));
    end
  end
endmodule

/* verif/sbt_top_tb.sv */
`timescale 1ns/1ps
// =====================================================================
// Bench: APB stimulus, pin checks
module sbt_top_tb;
  localparam int unsigned TICK = 4;
  logic        pclk, presetn, psel, penable, pwrite, host_access, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, spindle_at_speed, spindle_run;
  logic        standby, standby_z, cmd_busy, irq;
  logic [31:0] q;
  logic        e;
  logic [7:0]  codes [8];
  int          failures, total_checks;

  sbt_top #(.TICK_CYCLES(TICK)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_access(host_access),
    .spindle_at_speed(spindle_at_speed), .spindle_run(spindle_run), .standby(standby),
    .standby_z(standby_z), .cmd_busy(cmd_busy), .irq(irq));
  sbt_spindle_model spin (.pclk(pclk), .presetn(presetn), .slow(slow),
    .spindle_run(spindle_run), .spindle_at_speed(spindle_at_speed));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // =====================================================================
  // Closing report
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // =====================================================================
  // APB master; entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        failures++;
        $display("[FAIL] %0t pready got %0h exp %0h", $time, pready, 1'b1);
        conclude();
      end
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(q & m, x);
  endtask

  function automatic logic pin(input int s);
    case (s)
      0: return standby;
      1: return cmd_busy;
      2: return irq;
      3: return spindle_run;
      default: return standby_z;
    endcase
  endfunction

  // Sampled mid-cycle so that the edge's updates have landed
  task automatic pin_chk(input int s, input logic v);
    @(negedge pclk);
    chk({31'h0, pin(s)}, {31'h0, v});
    @(posedge pclk);
  endtask

  task automatic wait_pin(input int s, input logic v, input int bound);
    int n;
    n = 0;
    while (pin(s) !== v) begin
      @(posedge pclk);
      n++;
      if (n > bound) begin
        failures++;
        $display("[FAIL] %0t pin %0h got %0h exp %0h", $time, s, pin(s), v);
        conclude();
      end
    end
  endtask

  function automatic logic [15:0] exp_secs(input logic [7:0] c);
    if (c == 8'h00) return 16'h0000;
    if (c <= 8'hF0) return 16'(c * 5);
    if (c <= 8'hFB) return 16'((c - 8'hF0) * 1800);
    if (c == 8'hFC) return 16'(21 * 60);
    if (c == 8'hFD) return 16'(8 * 3600);
    return 16'(21 * 60 + 15);
  endfunction

  // =====================================================================
  // Main sequence
  initial begin
    failures = 0;
    total_checks = 0;
    codes = '{8'h00, 8'h01, 8'hF0, 8'hF1, 8'hFB, 8'hFC, 8'hFD, 8'hFF};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    host_access = 1'b0;
    slow = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    pin_chk(3, 1'b1);
    rd_chk(sbt_pkg::OFF_TIMER, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(sbt_pkg::OFF_INT_MASK, 32'h0000_000F);
    wr(sbt_pkg::OFF_CMD, {16'h0000, 8'h01, sbt_pkg::OP_STANDBY});
    wait_pin(0, 1'b1, 2);
    pin_chk(3, 1'b0);
    pin_chk(4, 1'b0);
    rd_chk(sbt_pkg::OFF_TIMER, 32'hFFFF_0000, {16'h0005, 16'h0000});
    pin_chk(2, 1'b1);
    wr(sbt_pkg::OFF_INT_STAT, 32'h0000_000F);
    pin_chk(2, 1'b0);
    // Eight sample codes, 254 left out so none aborts, while already stopped; opcodes alternate
    for (int i = 0; i < 8; i++) begin
      wr(sbt_pkg::OFF_CMD, {16'h0000, codes[i],
         i[0] ? sbt_pkg::OP_STANDBY_ALT : sbt_pkg::OP_STANDBY});
      rd_chk(sbt_pkg::OFF_TIMER, 32'hFFFF_0000, {exp_secs(codes[i]), 16'h0000});
      pin_chk(3, 1'b0);
    end
    wr(sbt_pkg::OFF_CMD, {16'h0000, 8'h01, sbt_pkg::OP_STANDBY});
    // Spin-up outlasts the interval, so counting early would expire at once
    host_access <= 1'b1;
    repeat (3) @(posedge pclk);
    host_access <= 1'b0;
    wait_pin(1, 1'b1, 8);
    pin_chk(3, 1'b1);
    wait_pin(1, 1'b0, 60);
    pin_chk(0, 1'b0);
    repeat (10) @(posedge pclk);
    host_access <= 1'b1;
    repeat (2) @(posedge pclk);
    host_access <= 1'b0;
    repeat (11) @(posedge pclk);
    pin_chk(0, 1'b0);
    wait_pin(0, 1'b1, 30);
    pin_chk(3, 1'b0);
    rd_chk(sbt_pkg::OFF_INT_STAT, 32'h0000_0004, 32'h0000_0004);
    wr(sbt_pkg::OFF_INT_MASK, 32'h0000_0000);
    wr(sbt_pkg::OFF_INT_STAT, 32'h0000_000F);
    wr(sbt_pkg::OFF_CMD, {16'h0000, 8'hFE, sbt_pkg::OP_STANDBY});
    rd_chk(sbt_pkg::OFF_STATUS, 32'h0000_01FF, 32'h0000_0104);
    pin_chk(2, 1'b0);
    rd_chk(sbt_pkg::OFF_INT_STAT, 32'h0000_000F, 32'h0000_0002);
    pin_chk(0, 1'b1);
    wr(sbt_pkg::OFF_INT_MASK, 32'h0000_0002);
    pin_chk(2, 1'b1);
    wr(sbt_pkg::OFF_INT_STAT, 32'h0000_0002);
    pin_chk(2, 1'b0);
    // Unknown opcode aborts too and leaves the interval alone
    wr(sbt_pkg::OFF_CMD, {16'h0000, 8'h01, 8'hE0});
    rd_chk(sbt_pkg::OFF_INT_STAT, 32'h0000_000F, 32'h0000_0002);
    rd_chk(sbt_pkg::OFF_TIMER, 32'hFFFF_0000, {16'h0005, 16'h0000});
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({q[30:0], e}, 32'h0000_0001);
    wr(sbt_pkg::OFF_CTRL, 32'h0000_0001);
    wr(sbt_pkg::OFF_CMD, {16'h0000, 8'h01, sbt_pkg::OP_STANDBY_ALT});
    pin_chk(4, 1'b1);
    conclude();
  end
endmodule
